// >>> dv/flash_ctrl_asserts.sv
// Purpose: Pin checks for flash_ctrl.
// Assumes: Serial clock slow against clk_sys.
// Notes: Helper counts rising serial edges per frame.
module flash_ctrl_asserts (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Pins
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe,
	input wire logic wp_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic sclk_q;
	logic [5:0] rises_q;
	logic [7:0] op_q;
	logic [3:0] fall_age_q;
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sclk_q <= 1'b0;
			rises_q <= 6'h00;
			op_q <= 8'h00;
			fall_age_q <= 4'hf;
		end else begin
			sclk_q <= sclk;
			if (sclk_q && !sclk)
				fall_age_q <= 4'h0;
			else if (fall_age_q != 4'hf)
				fall_age_q <= fall_age_q + 4'h1;
			if (cs_n)
				rises_q <= 6'h00;
			else if (sclk && !sclk_q && rises_q != 6'h3f) begin
				rises_q <= rises_q + 6'h01;
				if (rises_q < 6'h08)
					op_q <= {op_q[6:0], mosi};
			end
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rstn);
	oe_after_op_a: assert property ($rose(miso_oe) |-> op_q == 8'h05 || op_q == 8'h03)
		else $error("output enabled after other opcode");
	oe_bits_a: assert property ($rose(miso_oe) |-> rises_q >= 6'h08)
		else $error("output before eight clocks");
	read_addr_a: assert property ($rose(miso_oe) && op_q == 8'h03 |-> rises_q >= 6'h20)
		else $error("read output before address");
	miso_edge_a: assert property ($changed(miso) && $past(miso_oe) |-> fall_age_q <= 4'h6)
		else $error("data changed away from falling edge");
	oe_edge_a: assert property ($rose(miso_oe) |-> fall_age_q <= 4'h6 && !cs_n)
		else $error("output enable off edge");
	oe_hold_a: assert property (miso_oe && !cs_n ##1 !cs_n [*4] |-> miso_oe)
		else $error("output dropped while selected");
	oe_drop_a: assert property ($fell(miso_oe) |-> cs_n)
		else $error("output dropped without deselect");
	oe_release_a: assert property (cs_n [*8] |-> !miso_oe)
		else $error("output driven while deselected");
	status_cov_c: cover property ($rose(miso_oe) && op_q == 8'h05);
	read_cov_c: cover property ($rose(miso_oe) && op_q == 8'h03);
	pin_low_cov_c: cover property (!wp_n && $fell(cs_n));
endmodule : flash_ctrl_asserts

// >>> dv/flash_host_model.sv
// Purpose: Serial bus master driving flash_ctrl.
// Assumes: Mode 0, clock idle low, 320 ns period.
// Notes: Clock stands still between frames.
module flash_host_model (
	// Clock
	input wire logic clk_sys,
	// Serial link
	output logic sclk,
	output logic cs_n,
	output logic mosi,
	input wire logic miso
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	task automatic half;
		repeat (4) @(posedge clk_sys);
		#2;
	endtask : half
	task automatic open_frame;
		half();
		cs_n = 1'b0;
	endtask : open_frame
	// Sample at the fall, before the device moves on
	task automatic xfer(input logic [7:0] d, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) begin
			mosi = d[i];
			half();
			sclk = 1'b1;
			half();
			q[i] = miso;
			sclk = 1'b0;
		end
	endtask : xfer
	task automatic close_frame;
		half();
		cs_n = 1'b1;
		mosi = ~mosi;
		half();
		half();
	endtask : close_frame
endmodule : flash_host_model

// >>> dv/test_flash_ctrl.sv
// Purpose: Self-checking bench for flash_ctrl.
// Assumes: Short self-timed cycles via parameters.
// Notes: Reads table first, then status write, protection and program cases.
module test_flash_ctrl import flash_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	localparam longint BUSY_CYC = 1000;
	typedef struct {logic [23:0] addr; logic [7:0] first;} row_s;
	row_s rows [3] = '{'{24'h000010, 8'h10}, '{24'hf80020, 8'h20}, '{24'h07fffe, 8'hfe}};
	logic clk_sys, rstn, wp_n, sclk, cs_n, mosi, miso, miso_oe, oe_seen;
	logic [7:0] s, s2, r;
	int mismatches, compares;
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	flash_ctrl #(.STATUS_CYC(BUSY_CYC), .PROG_CYC(BUSY_CYC), .ERASE_CYC(BUSY_CYC)) u_flash_ctrl (
		.clk_sys(clk_sys), .rstn(rstn), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
		.miso(miso), .miso_oe(miso_oe), .wp_n(wp_n));
	flash_host_model u_flash_host_model (.clk_sys(clk_sys), .sclk(sclk), .cs_n(cs_n),
		.mosi(mosi), .miso(miso));
	always @(posedge clk_sys) if (miso_oe === 1'b1) oe_seen = 1'b1;
	task automatic wrap_up;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic cmd(input logic [7:0] op, input logic [7:0] d, input int n);
		u_flash_host_model.open_frame();
		u_flash_host_model.xfer(op, r);
		repeat (n) u_flash_host_model.xfer(d, r);
		u_flash_host_model.close_frame();
	endtask : cmd
	task automatic rd_sr(output logic [7:0] a, output logic [7:0] b);
		u_flash_host_model.open_frame();
		u_flash_host_model.xfer(OP_STATUS_READ, a);
		u_flash_host_model.xfer(8'h00, a);
		u_flash_host_model.xfer(8'h00, b);
		u_flash_host_model.close_frame();
	endtask : rd_sr
	task automatic wr_sr(input logic [7:0] d);
		cmd(OP_WRITE_ENABLE, 8'h00, 0);
		cmd(OP_STATUS_WRITE, d, 1);
	endtask : wr_sr
	task automatic wait_idle;
		for (int i = 0; i < 40; i++) begin
			rd_sr(s, s2);
			if (s2[0] === 1'b0)
				return;
		end
		mismatches++;
		$display("mismatch at %0t: busy stuck", $time);
		wrap_up();
	endtask : wait_idle
	task automatic pin(input logic v);
		@(posedge clk_sys) #2 wp_n = v;
	endtask : pin
	initial begin
		rstn = 1'b0;
		wp_n = 1'b1;
		oe_seen = 1'b0;
		mismatches = 0;
		compares = 0;
		repeat (16) @(posedge clk_sys);
		#2 rstn = 1'b1;
		repeat (8) @(posedge clk_sys);
		foreach (rows[k]) begin
			u_flash_host_model.open_frame();
			u_flash_host_model.xfer(OP_DATA_READ, r);
			for (int b = 2; b >= 0; b--) u_flash_host_model.xfer(rows[k].addr[b*8 +: 8], r);
			for (int b = 0; b < 3; b++) begin
				u_flash_host_model.xfer(8'h00, r);
				chk(r, rows[k].first + 8'(b), "read byte");
			end
			u_flash_host_model.close_frame();
		end
		$display("test reads done");
		rd_sr(s, s2);
		chk(s, 8'h00, "reset status");
		chk(s2, 8'h00, "repeat status");
		cmd(OP_STATUS_WRITE, 8'h9c, 1);
		rd_sr(s, s2);
		chk(s2, 8'h00, "write without latch");
		cmd(OP_WRITE_ENABLE, 8'h00, 0);
		cmd(OP_STATUS_WRITE, 8'hff, 2);
		rd_sr(s, s2);
		chk(s2, 8'h02, "long write kept out");
		cmd(OP_STATUS_WRITE, 8'hff, 1);
		rd_sr(s, s2);
		chk(s2 & 8'h03, 8'h03, "busy in cycle");
		oe_seen = 1'b0;
		cmd(OP_DATA_READ, 8'h00, 4);
		chk({7'h00, oe_seen}, 8'h00, "read while busy");
		wait_idle();
		chk(s2, 8'h9c, "written status");
		$display("test status write done");
		pin(1'b0);
		wr_sr(8'h00);
		rd_sr(s, s2);
		chk(s2 & 8'hfd, 8'h9c, "locked by pin");
		pin(1'b1);
		wr_sr(8'h00);
		wait_idle();
		chk(s2, 8'h00, "unlocked by pin");
		pin(1'b0);
		wr_sr(8'h1c);
		wait_idle();
		chk(s2, 8'h1c, "pin low, bit clear");
		cmd(OP_WRITE_ENABLE, 8'h00, 0);
		cmd(OP_BULK_ERASE, 8'h00, 0);
		rd_sr(s, s2);
		chk(s2 & 8'h01, 8'h00, "bulk erase ignored");
		wr_sr(8'h80);
		wait_idle();
		wr_sr(8'h00);
		rd_sr(s, s2);
		chk(s2 & 8'hfd, 8'h80, "locked after bit");
		$display("test protection done");
		cmd(OP_WRITE_ENABLE, 8'h00, 0);
		cmd(OP_SECTOR_ERASE, 8'h00, 2);
		rd_sr(s, s2);
		chk(s2, 8'h82, "short erase dropped");
		cmd(OP_WRITE_DISABLE, 8'h00, 0);
		rd_sr(s, s2);
		chk(s2, 8'h80, "latch cleared");
		cmd(OP_WRITE_ENABLE, 8'h00, 0);
		cmd(OP_PAGE_PROGRAM, 8'h00, 4);
		rd_sr(s, s2);
		chk(s2 & 8'h03, 8'h03, "program busy");
		wait_idle();
		chk(s2, 8'h80, "program done");
		$display("test program done");
		wrap_up();
	end
endmodule : test_flash_ctrl
bind flash_ctrl flash_ctrl_asserts u_flash_ctrl_asserts (.clk_sys(clk_sys), .rstn(rstn),
	.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso), .miso_oe(miso_oe), .wp_n(wp_n));

// >>> hdl/flash_ctrl.sv
// Purpose: Serial flash command decode, status register, protection and data read.
// Assumes: Serial clock, chip select, data in and write-protect are async pins.
// Notes: Array is a small RAM; program and erase only touch the status flow.
module flash_ctrl import flash_pkg::*; #(
	parameter int MEM_AW = 8,
	parameter longint STATUS_CYC = T_W_CYC,
	parameter longint PROG_CYC = T_PP_CYC,
	parameter longint ERASE_CYC = T_SE_CYC
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic mosi,
	output logic miso,
	output logic miso_oe,
	// Protection pin
	input wire logic wp_n
);
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_OPCODE,
		ST_ADDR,
		ST_SR_DATA,
		ST_SR_OUT,
		ST_RD_OUT,
		ST_IGNORE
	} ser_e;

	// Whole bytes a command needs before select rises; other counts are dropped, except that program takes more than LEN_ADDR_CMD
	localparam logic [2:0] LEN_OPCODE = 3'd1;
	localparam logic [2:0] LEN_SR_WRITE = 3'd2;
	localparam logic [2:0] LEN_ADDR_CMD = 3'(1 + ADDR_BYTES);

	// Pin idle levels: select and write-protect high, clock and data low
	localparam logic [3:0] PIN_IDLE = 4'b1100;
	localparam int PIN_SCLK = 1;
	localparam int PIN_CS = 2;

	// Two-stage synchronisers, one per pin; reset to idle so no false edge follows
	logic [3:0] pins;
	wire [3:0] pins_s;
	assign pins = {wp_n, cs_n, sclk, mosi};
	for (genvar g = 0; g < $bits(pins); g++) begin : g_sync
		logic meta_q, meta_d, stable_q, stable_d;
		always_comb begin
			meta_d = pins[g];
			stable_d = meta_q;
		end
		always_ff @(posedge clk_sys or negedge rstn) begin
			if (!rstn) begin
				meta_q <= PIN_IDLE[g];
				stable_q <= PIN_IDLE[g];
			end else begin
				meta_q <= meta_d;
				stable_q <= stable_d;
			end
		end
		assign pins_s[g] = stable_q;
	end

	// Last synchronised levels, for edge detection
	logic sclk_prev_q, sclk_prev_d, cs_prev_q, cs_prev_d;
	always_comb begin
		sclk_prev_d = pins_s[PIN_SCLK];
		cs_prev_d = pins_s[PIN_CS];
	end
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			sclk_prev_q <= PIN_IDLE[PIN_SCLK];
			cs_prev_q <= PIN_IDLE[PIN_CS];
		end else begin
			sclk_prev_q <= sclk_prev_d;
			cs_prev_q <= cs_prev_d;
		end
	end
	logic mosi_s, sclk_s, cs_s, wp_s;
	assign {wp_s, cs_s, sclk_s, mosi_s} = pins_s;
	logic rise, fall, cs_rise;
	assign rise = !cs_s && sclk_s && !sclk_prev_q;
	assign fall = !cs_s && !sclk_s && sclk_prev_q;
	assign cs_rise = cs_s && !cs_prev_q;

	logic [7:0] mem [2**MEM_AW];
	initial begin
		for (int i = 0; i < 2**MEM_AW; i++)
			mem[i] = 8'(i);
	end

	ser_e st_q, st_d;
	logic [2:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d;
	logic [7:0] op_q, op_d;
	logic [1:0] abyte_q, abyte_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [7:0] sr_new_q, sr_new_d;
	logic sr_full_q, sr_full_d;
	logic [7:0] out_sh_q, out_sh_d;
	logic miso_d, miso_oe_d;
	logic miso_q, miso_oe_q;
	logic [2:0] nbytes_q, nbytes_d;
	prot_s nv_q, nv_d;
	logic wel_q, wel_d;
	cycle_e cyc_q, cyc_d;
	logic [CYC_W-1:0] cnt_q, cnt_d;
	logic fetch_q, fetch_d;

	logic busy, hardware_protected_mode, sr_write_ok;
	logic [7:0] status;
	logic [7:0] byte_in;
	logic byte_done;
	assign busy = cyc_q != CYC_NONE;
	assign hardware_protected_mode = nv_q.prot_dis && !wp_s;
	assign sr_write_ok = wel_q && !busy && !hardware_protected_mode;
	// b6 and b5 always zero
	assign status = {nv_q.prot_dis, 2'b00, nv_q.bp, wel_q, busy};
	assign byte_in = {sh_q[6:0], mosi_s};
	assign byte_done = rise && bit_q == 3'(BYTE_BITS-1);

	// Read-byte buffer between array and shifter
	logic fi_valid, fi_ready, fo_valid, fo_ready, fifo_flush;
	logic [7:0] fo_data;
	assign fi_valid = fetch_q;
	assign fifo_flush = cs_s;
	flash_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.flush(fifo_flush),
		.in_valid(fi_valid),
		.in_ready(fi_ready),
		.in_data(mem[addr_q[MEM_AW-1:0]]),
		.out_valid(fo_valid),
		.out_ready(fo_ready),
		.out_data(fo_data)
	);

	// Serial protocol
	always_comb begin
		st_d = st_q;
		bit_d = bit_q;
		sh_d = sh_q;
		op_d = op_q;
		abyte_d = abyte_q;
		addr_d = addr_q;
		sr_new_d = sr_new_q;
		sr_full_d = sr_full_q;
		out_sh_d = out_sh_q;
		miso_d = miso_q;
		miso_oe_d = miso_oe_q;
		fetch_d = 1'b0;
		fo_ready = 1'b0;
		nbytes_d = nbytes_q;
		if (byte_done && nbytes_q != '1)
			nbytes_d = nbytes_q + 3'd1;
		if (rise) begin
			bit_d = bit_q + 3'd1;
			sh_d = byte_in;
			if (st_q == ST_SR_DATA && sr_full_q)
				sr_full_d = 1'b0;
		end
		// Fill while select stays low; stalls when buffer full
		if (st_q == ST_RD_OUT && fi_ready && !fetch_q && !fetch_d) begin
			fetch_d = 1'b1;
		end
		if (fetch_q) begin
			addr_d = (addr_q[ADDR_USED_W-1:0] == ADDR_TOP[ADDR_USED_W-1:0]) ? '0 : addr_q + 1'b1;
		end
		unique case (st_q)
			ST_IDLE: begin
				if (!cs_s) begin
					st_d = ST_OPCODE;
					bit_d = '0;
					sr_full_d = 1'b0;
					nbytes_d = '0;
				end
			end
			ST_OPCODE: begin
				if (byte_done) begin
					op_d = byte_in;
					unique case (byte_in)
						OP_STATUS_READ: begin
							st_d = ST_SR_OUT;
							out_sh_d = status;
						end
						OP_STATUS_WRITE: st_d = ST_SR_DATA;
						OP_DATA_READ: begin
							st_d = busy ? ST_IGNORE : ST_ADDR;
							abyte_d = '0;
						end
						OP_PAGE_PROGRAM, OP_SECTOR_ERASE: st_d = ST_ADDR;
						default: st_d = ST_IGNORE;
					endcase
				end
			end
			ST_ADDR: begin
				if (byte_done) begin
					addr_d = {addr_q[15:0], byte_in};
					abyte_d = abyte_q + 2'd1;
					if (abyte_q == 2'(ADDR_BYTES-1))
						st_d = (op_q == OP_DATA_READ) ? ST_RD_OUT : ST_IGNORE;
				end
			end
			ST_SR_DATA: begin
				if (byte_done) begin
					sr_new_d = byte_in;
					sr_full_d = 1'b1;
				end
			end
			ST_SR_OUT: begin
				if (fall) begin
					miso_oe_d = 1'b1;
					miso_d = out_sh_q[7];
					// Refresh at each byte boundary so busy clears mid-stream
					out_sh_d = (bit_q == '0) ? {status[6:0], 1'b0} : {out_sh_q[6:0], 1'b0};
					if (bit_q == '0)
						miso_d = status[7];
				end
			end
			ST_RD_OUT: begin
				if (fall) begin
					miso_oe_d = 1'b1;
					if (bit_q == '0) begin
						fo_ready = 1'b1;
						miso_d = fo_data[7];
						out_sh_d = {fo_data[6:0], 1'b0};
					end else begin
						miso_d = out_sh_q[7];
						out_sh_d = {out_sh_q[6:0], 1'b0};
					end
				end
			end
			ST_IGNORE: ;
		endcase
		if (cs_s && st_q != ST_IDLE) begin
			st_d = ST_IDLE;
			// Data line keeps its level; the enable alone marks it released
			miso_oe_d = 1'b0;
		end
	end

	assign miso = miso_q;
	assign miso_oe = miso_oe_q;

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			st_q <= ST_IDLE;
			bit_q <= '0;
			sh_q <= '0;
			op_q <= '0;
			abyte_q <= '0;
			addr_q <= '0;
			sr_new_q <= '0;
			sr_full_q <= 1'b0;
			out_sh_q <= '0;
			miso_q <= 1'b0;
			miso_oe_q <= 1'b0;
			fetch_q <= 1'b0;
			nbytes_q <= '0;
		end else begin
			st_q <= st_d;
			bit_q <= bit_d;
			sh_q <= sh_d;
			op_q <= op_d;
			abyte_q <= abyte_d;
			addr_q <= addr_d;
			sr_new_q <= sr_new_d;
			sr_full_q <= sr_full_d;
			out_sh_q <= out_sh_d;
			miso_q <= miso_d;
			miso_oe_q <= miso_oe_d;
			fetch_q <= fetch_d;
			nbytes_q <= nbytes_d;
		end
	end

	// Commands complete on chip select rising with whole bytes only
	logic frame_end, whole;
	assign frame_end = cs_rise && st_q != ST_IDLE;
	assign whole = bit_q == '0;
	logic [2:0] prot_bp;
	assign prot_bp = nv_q.bp;
	// A second data byte re-arms the full flag, so the byte count decides
	logic sr_len_ok;
	assign sr_len_ok = sr_full_q && nbytes_q == LEN_SR_WRITE;
	// Program needs address and data, erase exactly the address
	logic region_ok;
	assign region_ok = wel_q && prot_bp == '0 && ((op_q == OP_PAGE_PROGRAM) ?
		nbytes_q > LEN_ADDR_CMD : nbytes_q == LEN_ADDR_CMD);

	always_comb begin
		nv_d = nv_q;
		wel_d = wel_q;
		cyc_d = cyc_q;
		cnt_d = cnt_q;
		if (busy) begin
			if (cnt_q == '0) begin
				cyc_d = CYC_NONE;
				wel_d = 1'b0;
			end else
				cnt_d = cnt_q - 1'b1;
		end
		if (frame_end && whole && !busy) begin
			if (st_q == ST_IGNORE && op_q == OP_WRITE_ENABLE && nbytes_q == LEN_OPCODE)
				wel_d = 1'b1;
			if (st_q == ST_IGNORE && op_q == OP_WRITE_DISABLE && nbytes_q == LEN_OPCODE)
				wel_d = 1'b0;
			if (st_q == ST_SR_DATA && sr_len_ok && sr_write_ok) begin
				// Only protect-disable and block-protect bits change
				nv_d = {sr_new_q[SR_PROT_DIS], sr_new_q[SR_BP_HI:SR_BP_LO]};
				cyc_d = CYC_STATUS;
				cnt_d = CYC_W'(STATUS_CYC - 1);
			end
			if (st_q == ST_IGNORE && op_q == OP_BULK_ERASE && wel_q && nbytes_q == LEN_OPCODE) begin
				if (prot_bp == '0) begin
					cyc_d = CYC_ERASE;
					cnt_d = CYC_W'(ERASE_CYC - 1);
				end
			end
			// Protected-region check stands in for the real sector map
			if (op_q inside {OP_PAGE_PROGRAM, OP_SECTOR_ERASE} && region_ok) begin
				cyc_d = (op_q == OP_PAGE_PROGRAM) ? CYC_PROGRAM : CYC_ERASE;
				cnt_d = CYC_W'((op_q == OP_PAGE_PROGRAM) ? PROG_CYC - 1 : ERASE_CYC - 1);
			end
		end
	end

	// Protection bits model non-volatile cells; reset restores delivery state
	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			nv_q <= prot_s'(SR_NV_RESET[3:0]);
			wel_q <= 1'b0;
			cyc_q <= CYC_NONE;
			cnt_q <= '0;
		end else begin
			nv_q <= nv_d;
			wel_q <= wel_d;
			cyc_q <= cyc_d;
			cnt_q <= cnt_d;
		end
	end
endmodule : flash_ctrl

// >>> hdl/flash_fifo.sv
// Purpose: Small synchronous FIFO for outgoing read bytes.
// Assumes: Single clock; write ignored when full, read ignored when empty.
// Notes: Flush drops all content in one cycle.
module flash_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic flush,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW:0] wr_q, wr_d, rd_q, rd_d;
	logic push, pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign in_ready = (wr_q - rd_q) != (PW+1)'(DEPTH);
	assign out_valid = wr_q != rd_q;
	assign out_data = mem[rd_q[PW-1:0]];

	always_comb begin
		wr_d = flush ? rd_q : wr_q + (PW+1)'(push);
		rd_d = rd_q + (PW+1)'(pop && !flush);
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push)
			mem[wr_q[PW-1:0]] <= in_data;
	end
endmodule : flash_fifo

// >>> hdl/flash_pkg.sv
// Purpose: Constants, types and field layout for the serial flash command block.
// Assumes: 25 MHz system clock; serial clock is sampled, not used as a clock.
// Notes: Memory array is modelled small; top address bits are ignored.
package flash_pkg;
	localparam logic [7:0] OP_STATUS_READ = 8'h05;
	localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
	localparam logic [7:0] OP_DATA_READ = 8'h03;
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'hd8;
	localparam logic [7:0] OP_BULK_ERASE = 8'hc7;
	// Status register bit positions
	localparam int SR_BUSY = 0;
	localparam int SR_WEL = 1;
	localparam int SR_BP_LO = 2;
	localparam int SR_BP_HI = 4;
	localparam int SR_PROT_DIS = 7;
	// Bits a status write may change: protect-disable and block protect
	localparam logic [7:0] SR_WRITE_MASK = 8'h9c;
	localparam logic [7:0] SR_NV_RESET = 8'h00;
	localparam int ADDR_W = 24;
	localparam int ADDR_USED_W = 19;
	localparam logic [ADDR_W-1:0] ADDR_TOP = 24'h07ffff;
	localparam int BYTE_BITS = 8;
	localparam int ADDR_BYTES = 3;
	// Self-timed cycle lengths
	localparam int CLK_HZ = 25_000_000;
	localparam int T_W_US = 15_000;
	localparam int T_PP_US = 5_000;
	localparam int T_SE_US = 3_000_000;
	localparam longint T_W_CYC = longint'(T_W_US) * CLK_HZ / 1_000_000;
	localparam longint T_PP_CYC = longint'(T_PP_US) * CLK_HZ / 1_000_000;
	localparam longint T_SE_CYC = longint'(T_SE_US) * CLK_HZ / 1_000_000;
	localparam int CYC_W = 32;
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [1:0] {
		CYC_NONE,
		CYC_STATUS,
		CYC_PROGRAM,
		CYC_ERASE
	} cycle_e;

	typedef struct packed {
		logic prot_dis;
		logic [2:0] bp;
	} prot_s;
endpackage : flash_pkg
